// *** rtl/rew_pkg.sv ***
// Package with register map, field layout, reset values and decode tables.
package rew_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam int          ADDR_W              = 8;
    localparam int          DATA_W              = 8;
    localparam logic [7:0]  OFF_EC_WINDOWS      = 8'h17;
    localparam logic [7:0]  OFF_PI_PROP_GAIN    = 8'h18;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int          EXTRA_WIN_LSB       = 2;
    localparam int          MISSED_WIN_LSB      = 0;
    localparam int          DIV_SEL_LSB         = 5;
    localparam int          NUMER_LSB           = 0;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [1:0]  EXTRA_WIN_RST       = 2'h1;
    localparam logic [1:0]  MISSED_WIN_RST      = 2'h1;
    localparam logic [2:0]  DIV_SEL_RST         = 3'h1;
    localparam logic [4:0]  NUMER_RST           = 5'h01;
    localparam logic [7:0]  PI_PROP_GAIN_RST    = 8'h21;

    // ------------------------------------------------------------------
    // Window percentages and divisor shifts
    // ------------------------------------------------------------------
    localparam logic [6:0]  WIN_PCT_0           = 7'h14;
    localparam logic [6:0]  WIN_PCT_1           = 7'h1E;
    localparam logic [6:0]  WIN_PCT_2           = 7'h28;
    localparam logic [6:0]  WIN_PCT_3           = 7'h32;
    localparam logic [7:0]  PCT_FULL            = 8'h64;
    localparam logic [3:0]  DIV_SHIFT_UNDEF     = 4'h9;

    // Log2 of the proportional divisor for each selector code.
    function automatic logic [3:0] div_shift(input logic [2:0] sel);
        case (sel)
            3'h0:    div_shift = 4'h5;
            3'h1:    div_shift = 4'h6;
            3'h2:    div_shift = 4'h7;
            3'h3:    div_shift = 4'h8;
            3'h4:    div_shift = 4'h9;
            3'h5:    div_shift = 4'h4;
            3'h6:    div_shift = 4'h0;
            default: div_shift = DIV_SHIFT_UNDEF;
        endcase
    endfunction

endpackage

// *** rtl/rew_window_decode.sv ***
// Decoder from a 2-bit window code to its percentage.
`timescale 1ns/100ps
module rew_window_decode
    import rew_pkg::*;
(
    // Window code in.
    input  wire logic [1:0] code,
    // Window width out, in percent.
    output logic      [6:0] pct
);

    always_comb begin
        case (code)
            2'h0:    pct = WIN_PCT_0;
            2'h1:    pct = WIN_PCT_1;
            2'h2:    pct = WIN_PCT_2;
            default: pct = WIN_PCT_3;
        endcase
    end

endmodule

// *** rtl/rew_ripple_pi_cfg.sv ***
// Ripple error windows, proportional gain register and proportional term.
//
// The strobed register port was left to the implementer.
`timescale 1ns/100ps
module rew_ripple_pi_cfg
    import rew_pkg::*;
#(
    parameter int ERR_W = 16,
    parameter int PER_W = 16
)(
    // Clock and reset.
    input  wire logic                    core_clk,
    input  wire logic                    resetn,
    // Register port.
    input  wire logic [rew_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [rew_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    output logic      [rew_pkg::DATA_W-1:0] reg_rdata,
    // Ripple interval classification.
    input  wire logic [PER_W-1:0]        expected_period,
    input  wire logic [PER_W-1:0]        ripple_interval,
    input  wire logic                    ripple_valid,
    output logic                         extra_ripple,
    output logic                         missed_ripple,
    output logic      [6:0]              extra_window_pct,
    output logic      [6:0]              missed_window_pct,
    // Proportional term of the speed loop.
    input  wire logic signed [ERR_W-1:0] speed_error,
    input  wire logic                    error_valid,
    output logic signed [ERR_W+4:0]      prop_term,
    output logic                         prop_valid,
    output logic      [9:0]              prop_divisor
);

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    logic [1:0] extra_ripple_window;
    logic [1:0] missed_ripple_window;
    logic [2:0] prop_gain_divisor_sel;
    logic [4:0] prop_gain_numerator;
    logic [1:0] next_extra_ripple_window;
    logic [1:0] next_missed_ripple_window;
    logic [2:0] next_prop_gain_divisor_sel;
    logic [4:0] next_prop_gain_numerator;
    logic [7:0] next_reg_rdata;
    logic       wr_ec;
    logic       wr_gain;

    assign wr_ec   = reg_wr && (reg_addr == OFF_EC_WINDOWS);
    assign wr_gain = reg_wr && (reg_addr == OFF_PI_PROP_GAIN);

    always_comb begin
        next_extra_ripple_window   = extra_ripple_window;
        next_missed_ripple_window  = missed_ripple_window;
        next_prop_gain_divisor_sel = prop_gain_divisor_sel;
        next_prop_gain_numerator   = prop_gain_numerator;
        if (wr_ec) begin
            next_extra_ripple_window  = reg_wdata[EXTRA_WIN_LSB +: 2];
            next_missed_ripple_window = reg_wdata[MISSED_WIN_LSB +: 2];
        end
        if (wr_gain) begin
            next_prop_gain_divisor_sel = reg_wdata[DIV_SEL_LSB +: 3];
            next_prop_gain_numerator   = reg_wdata[NUMER_LSB +: 5];
        end
        next_reg_rdata = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                OFF_EC_WINDOWS:   next_reg_rdata = {4'h0, extra_ripple_window,
                                                    missed_ripple_window};
                OFF_PI_PROP_GAIN: next_reg_rdata = {prop_gain_divisor_sel,
                                                    prop_gain_numerator};
                default:          next_reg_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            extra_ripple_window   <= EXTRA_WIN_RST;
            missed_ripple_window  <= MISSED_WIN_RST;
            prop_gain_divisor_sel <= DIV_SEL_RST;
            prop_gain_numerator   <= NUMER_RST;
            reg_rdata             <= 8'h00;
        end else begin
            extra_ripple_window   <= next_extra_ripple_window;
            missed_ripple_window  <= next_missed_ripple_window;
            prop_gain_divisor_sel <= next_prop_gain_divisor_sel;
            prop_gain_numerator   <= next_prop_gain_numerator;
            reg_rdata             <= next_reg_rdata;
        end
    end

    // ------------------------------------------------------------------
    // Ripple window classification
    // ------------------------------------------------------------------
    logic [6:0]  extra_pct;
    logic [6:0]  missed_pct;
    logic [23:0] interval_scaled;
    logic [23:0] extra_limit;
    logic [23:0] missed_limit;
    logic        next_extra_ripple;
    logic        next_missed_ripple;

    rew_window_decode u_extra_dec (
        .code (extra_ripple_window),
        .pct  (extra_pct)
    );

    rew_window_decode u_missed_dec (
        .code (missed_ripple_window),
        .pct  (missed_pct)
    );

    always_comb begin
        interval_scaled    = 24'(ripple_interval) * 24'(PCT_FULL);
        extra_limit        = 24'(expected_period) * 24'(extra_window_pct);
        missed_limit       = 24'(expected_period)
                             * (24'(PCT_FULL) + 24'(missed_window_pct));
        next_extra_ripple  = ripple_valid && (interval_scaled < extra_limit);
        next_missed_ripple = ripple_valid && (interval_scaled > missed_limit);
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            extra_window_pct  <= WIN_PCT_1;
            missed_window_pct <= WIN_PCT_1;
            extra_ripple      <= 1'b0;
            missed_ripple     <= 1'b0;
        end else begin
            extra_window_pct  <= extra_pct;
            missed_window_pct <= missed_pct;
            extra_ripple      <= next_extra_ripple;
            missed_ripple     <= next_missed_ripple;
        end
    end

    // ------------------------------------------------------------------
    // Proportional term
    // ------------------------------------------------------------------
    logic [3:0]              gain_shift;
    logic signed [ERR_W+5:0] gain_product;
    logic signed [ERR_W+4:0] next_prop_term;
    logic [9:0]              next_prop_divisor;

    always_comb begin
        gain_shift        = div_shift(prop_gain_divisor_sel);
        next_prop_divisor = 10'(11'h001 << gain_shift);
        gain_product      = (ERR_W+6)'(speed_error)
                            * $signed({1'b0, prop_gain_numerator});
        next_prop_term    = (ERR_W+5)'(gain_product >>> gain_shift);
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            prop_term    <= '0;
            prop_valid   <= 1'b0;
            prop_divisor <= 10'h040;
        end else begin
            prop_term    <= error_valid ? next_prop_term : prop_term;
            prop_valid   <= error_valid;
            prop_divisor <= next_prop_divisor;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    logic gain_written;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            gain_written <= 1'b0;
        end else if (wr_gain) begin
            gain_written <= 1'b1;
        end
    end

    chk_extra_window_pct: assert property (
        wr_ec |=> ##1 extra_window_pct ==
            (($past(reg_wdata, 2) & 8'h0C) == 8'h00 ? 7'd20 :
             ($past(reg_wdata, 2) & 8'h0C) == 8'h04 ? 7'd30 :
             ($past(reg_wdata, 2) & 8'h0C) == 8'h08 ? 7'd40 : 7'd50))
        else $error("Extra ripple window percent does not follow written code.");

    chk_missed_window_rst: assert property (
        $rose(resetn) |-> (missed_window_pct == 7'd30) [*2])
        else $error("Missed ripple window does not start at thirty percent.");

    chk_missed_flag: assert property (
        ripple_valid && ripple_interval == expected_period |=> !missed_ripple && !extra_ripple)
        else $error("Ripple on the nominal period was classified as an error.");

    chk_divisor_map: assert property (
        prop_gain_divisor_sel == 3'b101 |=> prop_divisor == 10'd16)
        else $error("Selector code five does not give divisor sixteen.");

    chk_prop_gain: assert property (
        error_valid && prop_gain_divisor_sel == 3'b110 |=>
            prop_term == ($past(speed_error) * $signed({1'b0, $past(prop_gain_numerator)})))
        else $error("Proportional term with divisor one is not error times numerator.");

    chk_gain_reset: assert property (
        reg_rd && reg_addr == OFF_PI_PROP_GAIN && !gain_written |=> reg_rdata == 8'h21)
        else $error("Gain register does not read its reset value.");

    chk_undef_sel: assert property (
        prop_gain_divisor_sel == 3'b111 |=> prop_divisor == 10'd512)
        else $error("Undefined selector is not treated as divisor 512.");

    // ------------------------------------------------------------------
    // Field decode, classification and gain checks
    // ------------------------------------------------------------------
    logic ec_written;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ec_written <= 1'b0;
        end else if (wr_ec) begin
            ec_written <= 1'b1;
        end
    end

    chk_missed_window_pct: assert property (
        wr_ec |=> ##1 missed_window_pct ==
            (($past(reg_wdata, 2) & 8'h03) == 8'h00 ? 7'h14 :
             ($past(reg_wdata, 2) & 8'h03) == 8'h01 ? 7'h1E :
             ($past(reg_wdata, 2) & 8'h03) == 8'h02 ? 7'h28 : 7'h32))
        else $error("Missed ripple window percent does not follow written code.");

    chk_window_reg_rst: assert property (
        reg_rd && reg_addr == OFF_EC_WINDOWS && !ec_written |=> reg_rdata == 8'h05)
        else $error("Window register does not read its reset codes.");

    chk_extra_pct_range: assert property (
        extra_window_pct inside {7'h14, 7'h1E, 7'h28, 7'h32})
        else $error("Extra ripple window percent is outside the four settings.");

    chk_missed_pct_range: assert property (
        missed_window_pct inside {7'h14, 7'h1E, 7'h28, 7'h32})
        else $error("Missed ripple window percent is outside the four settings.");

    chk_extra_short: assert property (
        ripple_valid && ripple_interval == '0 && expected_period != '0
            |=> extra_ripple)
        else $error("Ripple with no interval was not classified as extra.");

    chk_missed_long: assert property (
        ripple_valid && {1'b0, ripple_interval} > {expected_period, 1'b0}
            |=> missed_ripple)
        else $error("Ripple after twice the period was not classified as missed.");

    chk_flags_idle: assert property (
        !ripple_valid |=> !extra_ripple && !missed_ripple)
        else $error("Ripple flag raised without a ripple.");

    chk_flags_exclusive: assert property (
        !(extra_ripple && missed_ripple))
        else $error("Ripple classified as extra and missed at once.");

    chk_divisor_table: assert property (
        prop_divisor ==
            ($past(prop_gain_divisor_sel) == 3'h0 ? 10'h020 :
             $past(prop_gain_divisor_sel) == 3'h1 ? 10'h040 :
             $past(prop_gain_divisor_sel) == 3'h2 ? 10'h080 :
             $past(prop_gain_divisor_sel) == 3'h3 ? 10'h100 :
             $past(prop_gain_divisor_sel) == 3'h4 ? 10'h200 :
             $past(prop_gain_divisor_sel) == 3'h5 ? 10'h010 :
             $past(prop_gain_divisor_sel) == 3'h6 ? 10'h001 : 10'h200))
        else $error("Divisor does not follow the selector table.");

    chk_prop_div16: assert property (
        error_valid && prop_gain_divisor_sel == 3'h5 |=>
            prop_term == (($past(speed_error)
                           * $signed({1'b0, $past(prop_gain_numerator)})) >>> 4))
        else $error("Proportional term with divisor sixteen is wrong.");

    chk_prop_undef_gain: assert property (
        error_valid && prop_gain_divisor_sel == 3'h7 |=>
            prop_term == (($past(speed_error)
                           * $signed({1'b0, $past(prop_gain_numerator)})) >>> 9))
        else $error("Proportional term with undefined selector is not divided by 512.");

    chk_prop_hold: assert property (
        !error_valid |=> $stable(prop_term))
        else $error("Proportional term changed without a new error sample.");

    chk_prop_valid: assert property (
        prop_valid == $past(error_valid))
        else $error("Proportional valid does not follow the error strobe by one cycle.");

    chk_undef_readback: assert property (
        reg_rd && reg_addr == OFF_PI_PROP_GAIN && prop_gain_divisor_sel == 3'h7
            |=> reg_rdata[7:5] == 3'h7)
        else $error("Undefined selector is not read back as written.");

    cov_extra_seen:  cover property (ripple_valid ##1 extra_ripple);
    cov_missed_seen: cover property (ripple_valid ##1 missed_ripple);
    cov_gain_write:  cover property (wr_gain ##1 reg_rd && reg_addr == OFF_PI_PROP_GAIN);
    cov_prop_valid:  cover property (error_valid ##1 prop_valid && prop_term != '0);
    cov_undef_sel:   cover property (wr_gain ##1 prop_gain_divisor_sel == 3'h7);

endmodule

// *** testbench/rew_host.sv ***
// Host model that configures the block over its register port.
`timescale 1ns/100ps
module rew_host (
    // Clock.
    input  wire logic       core_clk,
    // Register port.
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata,
    output logic            reg_wr,
    output logic            reg_rd,
    input  wire logic [7:0] reg_rdata
);
    import rew_pkg::*;
    initial begin
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end
    // Writes one register; selector code 111b is never sent.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= (a == OFF_PI_PROP_GAIN && d[7:5] == 3'h7) ? {3'h4, d[4:0]} : d;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
        reg_wdata <= ~d;
    endtask
    // Corner case only: writes any value, the undefined selector included.
    task automatic wr_raw(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
        reg_wdata <= ~d;
    endtask
    // Reads one register; data stand in the cycle after the strobe.
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
endmodule

// *** testbench/tb_ripple_error_window_pi_gain.sv ***
// Self-checking testbench for the ripple windows and proportional gain.
`timescale 1ns/100ps
module tb_ripple_error_window_pi_gain;
    import rew_pkg::*;
    logic               core_clk;
    logic               resetn;
    logic        [7:0]  reg_addr;
    logic        [7:0]  reg_wdata;
    logic               reg_wr;
    logic               reg_rd;
    logic        [7:0]  reg_rdata;
    logic        [15:0] expected_period;
    logic        [15:0] ripple_interval;
    logic               ripple_valid;
    logic               extra_ripple;
    logic               missed_ripple;
    logic        [6:0]  extra_window_pct;
    logic        [6:0]  missed_window_pct;
    logic signed [15:0] speed_error;
    logic               error_valid;
    logic signed [20:0] prop_term;
    logic               prop_valid;
    logic        [9:0]  prop_divisor;
    logic        [7:0]  rd_data;
    logic        [15:0] per;
    int                 seed;
    int                 mismatches;
    int                 total_checks;

    rew_ripple_pi_cfg dut (.core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .expected_period(expected_period), .ripple_interval(ripple_interval),
        .ripple_valid(ripple_valid), .extra_ripple(extra_ripple),
        .missed_ripple(missed_ripple), .extra_window_pct(extra_window_pct),
        .missed_window_pct(missed_window_pct), .speed_error(speed_error),
        .error_valid(error_valid), .prop_term(prop_term), .prop_valid(prop_valid),
        .prop_divisor(prop_divisor));
    rew_host host (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

    // ------------------------------------------------------------------
    // Expectations and checks
    // ------------------------------------------------------------------
    function automatic logic [6:0] win_pct(input logic [1:0] c);
        return 7'(20 + 10 * c);
    endfunction
    function automatic logic [9:0] divisor(input logic [2:0] s);
        case (s)
            3'h5: return 10'h010;
            3'h6: return 10'h001;
            3'h7: return 10'h200;
            default: return 10'(32 << s);
        endcase
    endfunction
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s expected %0h seen %0h", name, exp, seen);
        end
    endtask
    task automatic final_report();
        if (mismatches == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic ripple(input logic [15:0] p, input logic [15:0] i, input logic [3:0] w);
        @(posedge core_clk);
        ripple_valid    <= 1'b1;
        expected_period <= p;
        ripple_interval <= i;
        @(posedge core_clk);
        ripple_valid    <= 1'b0;
        #1;
        check("extra_ripple", extra_ripple, 32'(longint'(i) * 100 < p * win_pct(w[3:2])));
        check("missed_ripple", missed_ripple,
              32'(longint'(i) * 100 > p * (100 + win_pct(w[1:0]))));
    endtask
    task automatic gain(input logic [2:0] s, input logic [4:0] n, input logic signed [15:0] e);
        if (s == 3'h7) begin
            host.wr_raw(OFF_PI_PROP_GAIN, {s, n});
        end else begin
            host.wr(OFF_PI_PROP_GAIN, {s, n});
        end
        host.rd(OFF_PI_PROP_GAIN, rd_data);
        check("gain_reg", rd_data, {s, n});
        check("prop_divisor", prop_divisor, divisor(s));
        @(posedge core_clk);
        error_valid <= 1'b1;
        speed_error <= e;
        @(posedge core_clk);
        error_valid <= 1'b0;
        #1;
        check("prop_valid", prop_valid, 1);
        check("prop_term", prop_term, 21'((longint'(e) * longint'(n)) >>> $clog2(divisor(s))));
    endtask

    // ------------------------------------------------------------------
    // Clock, watchdog and main sequence
    // ------------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    initial begin
        repeat (5000) @(posedge core_clk);
        mismatches++;
        final_report();
    end
    initial begin
        seed = 47356;
        resetn = 1'b0;
        expected_period = 16'h0000;
        ripple_interval = 16'h0000;
        ripple_valid = 1'b0;
        speed_error = 16'h0000;
        error_valid = 1'b0;
        repeat (20) @(posedge core_clk);
        resetn <= 1'b1;
        host.rd(OFF_EC_WINDOWS, rd_data);
        check("window_reg", rd_data, 8'h05);
        host.rd(OFF_PI_PROP_GAIN, rd_data);
        check("gain_reg", rd_data, 8'h21);
        check("prop_divisor", prop_divisor, 10'h040);
        check("missed_pct", missed_window_pct, 7'h1E);
        ripple(16'h0064, 16'h000A, 4'h5);
        ripple(16'h0064, 16'h0000, 4'h5);
        ripple(16'h0064, 16'hFFFF, 4'h5);
        host.wr(8'h40, 8'hFF);
        host.rd(8'h40, rd_data);
        check("unmapped", rd_data, 8'h00);
        gain(3'h1, 5'h01, 16'sh0280);
        for (int w = 0; w < 16; w++) begin
            host.wr(OFF_EC_WINDOWS, 8'(w));
            repeat (2) @(posedge core_clk);
            #1;
            check("extra_pct", extra_window_pct, win_pct(2'(w >> 2)));
            check("missed_pct", missed_window_pct, win_pct(2'(w)));
            ripple(16'h0064, 16'(win_pct(2'(w >> 2))), 4'(w));
            ripple(16'h0064, 16'(100 + win_pct(2'(w))), 4'(w));
            repeat (4) begin
                per = 16'($random(seed)) | 16'h0001;
                ripple(per, 16'(longint'(per) * ($unsigned($random(seed)) % 200) / 100), 4'(w));
            end
        end
        for (int s = 0; s < 8; s++) begin
            gain(3'(s), 5'($random(seed)), 16'($random(seed)));
            gain(3'(s), 5'h1F, 16'sh8000);
        end
        final_report();
    end
endmodule
